// [frt_defs.svh]
// constants for the free-running timer block
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH
`define FRT_ADDR_W        4
`define FRT_OFF_OPTION    4'h0
`define FRT_OFF_COUNT     4'h4
`define FRT_OFF_STATUS    4'h8
`define FRT_OPT_RESET     8'hFF
`define FRT_OPT_SRC       5
`define FRT_OPT_EDGE      4
`define FRT_OPT_ASSIGN    3
`define FRT_OPT_IEN       7
`define FRT_PS_LO         0
`define FRT_PS_HI         2
`define FRT_CNT_RESET     8'h00
`define FRT_CNT_MAX       8'hFF
`define FRT_CNT_MIN       8'h00
`define FRT_PS_RESET      8'h00
`define FRT_RESP_OKAY     2'b00
`define FRT_RESP_SLVERR   2'b10
`endif

// [frt_edge_sync.sv]
// synchroniser and edge detector for the timer input pin
`timescale 1ns/100ps
`include "frt_defs.svh"
module frt_edge_sync (
	input  wire logic CLK,
	input  wire logic RESET,
	input  wire logic pin_in,
	input  wire logic fall_sel,
	output logic      edge_pulse
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;
	wire  rise_w = sync_ff & ~last_ff;
	wire  fall_w = ~sync_ff & last_ff;

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	// one pulse per qualifying edge
	assign edge_pulse = fall_sel ? fall_w : rise_w;

	one_pulse_a: assert property (@(posedge CLK) disable iff (RESET)
		edge_pulse |=> !edge_pulse) else $error("edge pulse longer than one cycle");
endmodule

// [frt_pkg.sv]
// types for the free-running timer block
package frt_pkg;
	typedef struct packed {
		logic        ien;
		logic        rsvd;
		logic        src_ext;
		logic        fall_edge;
		logic        assign_wd;
		logic [2:0]  div_sel;
	} frt_option_t;

	typedef struct packed {
		logic [3:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [3:0]  araddr;
		logic        arvalid;
		logic        rready;
	} frt_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} frt_axi_rsp_t;
endpackage

// [frt_prescaler.sv]
// 8-bit prescaler shared by timer and watchdog
`timescale 1ns/100ps
`include "frt_defs.svh"
module frt_prescaler (
	input  wire logic       CLK,
	input  wire logic       RESET,
	input  wire logic       tick_in,
	input  wire logic [2:0] div_sel,
	output logic            tick_out
);
	logic [7:0] count_ff;
	logic [7:0] nxt_count;

	// power-of-two ratio 1:2 .. 1:256
	function automatic logic [7:0] div_mask(input logic [2:0] sel);
		div_mask = 8'((9'h002 << sel) - 9'h001);
	endfunction

	wire [7:0] mask_w = div_mask(div_sel);
	assign tick_out = tick_in & ((count_ff & mask_w) == mask_w);
	assign nxt_count = tick_in ? count_ff + 8'h01 : count_ff;

	// count not reachable from software
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET)
			count_ff <= `FRT_PS_RESET;
		else
			count_ff <= nxt_count;
	end

	out_needs_in_a: assert property (@(posedge CLK) disable iff (RESET)
		tick_out |-> tick_in) else $error("prescaler output without input");
endmodule

// [frt_timer.sv]
// free-running timer with prescaler and AXI4-Lite register slave
`timescale 1ns/100ps
`include "frt_defs.svh"
module frt_timer
	import frt_pkg::*;
(
	input  wire logic                  CLK,
	input  wire logic                  RESET,
	input  wire logic                  TIMER_INPUT_PIN,
	input  wire logic                  WATCHDOG_TICK,
	input  wire frt_pkg::frt_axi_req_t AXI_REQ,
	output frt_pkg::frt_axi_rsp_t      AXI_RSP,
	output logic                       TIMER_IRQ,
	output logic                       WATCHDOG_POST_TICK
);
	import frt_pkg::*;

	// ****************************************
	// option and count state
	// ****************************************
	frt_option_t option_ff;
	logic [7:0]  count_ff;
	logic [7:0]  nxt_count;
	logic        irq_ff;
	logic        ext_edge;
	logic        ps_out;

	frt_edge_sync u_sync (
		.CLK        (CLK),
		.RESET      (RESET),
		.pin_in     (TIMER_INPUT_PIN),
		.fall_sel   (option_ff.fall_edge),
		.edge_pulse (ext_edge)
	);

	// ****************************************
	// source selection and prescaler routing
	// ****************************************
	wire src_tick  = option_ff.src_ext ? ext_edge : 1'b1;
	wire ps_to_wd  = option_ff.assign_wd;
	wire ps_in     = ps_to_wd ? WATCHDOG_TICK : src_tick;
	wire cnt_tick  = ps_to_wd ? src_tick : ps_out;
	wire rollover  = cnt_tick & (count_ff == `FRT_CNT_MAX);

	frt_prescaler u_ps (
		.CLK      (CLK),
		.RESET    (RESET),
		.tick_in  (ps_in),
		.div_sel  (option_ff.div_sel),
		.tick_out (ps_out)
	);

	assign WATCHDOG_POST_TICK = ps_to_wd ? ps_out : WATCHDOG_TICK;

	// ****************************************
	// register bus decode
	// ****************************************
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [3:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	wire aw_take  = AXI_REQ.awvalid & ~aw_held_ff & ~bvalid_ff;
	wire w_take   = AXI_REQ.wvalid & ~w_held_ff & ~bvalid_ff;
	wire aw_have  = aw_held_ff | aw_take;
	wire w_have   = w_held_ff | w_take;
	wire [3:0] wr_addr   = aw_held_ff ? awaddr_ff : AXI_REQ.awaddr;
	wire [31:0] wr_data  = w_held_ff ? wdata_ff : AXI_REQ.wdata;
	wire [3:0] wr_strb   = w_held_ff ? wstrb_ff : AXI_REQ.wstrb;
	wire wr_fire  = aw_have & w_have & ~bvalid_ff;
	wire wr_opt   = wr_fire & (wr_addr == `FRT_OFF_OPTION) & wr_strb[0];
	wire wr_cnt   = wr_fire & (wr_addr == `FRT_OFF_COUNT) & wr_strb[0];
	wire wr_known = (wr_addr == `FRT_OFF_OPTION) | (wr_addr == `FRT_OFF_COUNT);
	wire rd_take  = AXI_REQ.arvalid & ~rvalid_ff;
	wire rd_opt   = AXI_REQ.araddr == `FRT_OFF_OPTION;
	wire rd_cnt   = AXI_REQ.araddr == `FRT_OFF_COUNT;
	wire rd_stat  = AXI_REQ.araddr == `FRT_OFF_STATUS;
	// status shows which user owns the prescaler (bit 0) and the one-cycle request (bit 1); no sticky overflow flag
	wire [31:0] rd_mux = rd_opt  ? {24'h00_0000, option_ff} :
	                     rd_cnt  ? {24'h00_0000, count_ff} :
	                     rd_stat ? {30'h0000_0000, irq_ff, ps_to_wd} : 32'h0000_0000;

	assign AXI_RSP.awready = aw_take;
	assign AXI_RSP.wready  = w_take;
	assign AXI_RSP.bvalid  = bvalid_ff;
	assign AXI_RSP.bresp   = bresp_ff;
	assign AXI_RSP.arready = rd_take;
	assign AXI_RSP.rvalid  = rvalid_ff;
	assign AXI_RSP.rdata   = rdata_ff;
	assign AXI_RSP.rresp   = rresp_ff;

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awaddr_ff  <= 4'h0;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `FRT_RESP_OKAY;
		end else begin
			if (aw_take) begin
				awaddr_ff <= AXI_REQ.awaddr;
			end
			if (w_take) begin
				wdata_ff <= AXI_REQ.wdata;
				wstrb_ff <= AXI_REQ.wstrb;
			end
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_known ? `FRT_RESP_OKAY : `FRT_RESP_SLVERR;
			end else begin
				aw_held_ff <= aw_have;
				w_held_ff  <= w_have;
				if (bvalid_ff & AXI_REQ.bready)
					bvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= `FRT_RESP_OKAY;
		end else if (rd_take) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_mux;
			rresp_ff  <= (rd_opt | rd_cnt | rd_stat) ? `FRT_RESP_OKAY : `FRT_RESP_SLVERR;
		end else if (rvalid_ff & AXI_REQ.rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ****************************************
	// counter and interrupt request
	// ****************************************
	// a software write wins over a same-cycle count step
	assign nxt_count = wr_cnt ? wr_data[7:0] :
	                   cnt_tick ? count_ff + 8'h01 : count_ff;

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			option_ff <= `FRT_OPT_RESET;
			count_ff  <= `FRT_CNT_RESET;
			irq_ff    <= 1'b0;
		end else begin
			if (wr_opt)
				option_ff <= wr_data[7:0];
			count_ff <= nxt_count;
			irq_ff   <= rollover & option_ff.ien & ~wr_cnt;
		end
	end

	// one-cycle request, no sticky pending state
	assign TIMER_IRQ = irq_ff;

	// ****************************************
	// checks
	// ****************************************
	sequence wrap_seq;
		cnt_tick && !wr_cnt && count_ff == `FRT_CNT_MAX && option_ff.ien;
	endsequence

	irq_on_wrap_a: assert property (@(posedge CLK) disable iff (RESET)
		wrap_seq |=> TIMER_IRQ && count_ff == `FRT_CNT_MIN) else $error("missing rollover request");
	irq_gated_a: assert property (@(posedge CLK) disable iff (RESET)
		!option_ff.ien |=> !TIMER_IRQ) else $error("request while disabled");
	irq_cause_a: assert property (@(posedge CLK) disable iff (RESET)
		TIMER_IRQ |-> $past(count_ff) == `FRT_CNT_MAX) else $error("request without wrap");
	irq_no_pend_a: assert property (@(posedge CLK) disable iff (RESET)
		TIMER_IRQ |=> !TIMER_IRQ) else $error("request held like a pending flag");
	internal_step_a: assert property (@(posedge CLK) disable iff (RESET)
		!option_ff.src_ext && option_ff.assign_wd && !wr_cnt && !wr_opt
		|=> count_ff == $past(count_ff) + 8'h01) else $error("internal source missed step");
	ext_hold_a: assert property (@(posedge CLK) disable iff (RESET)
		option_ff.src_ext && option_ff.assign_wd && !ext_edge && !wr_cnt
		|=> count_ff == $past(count_ff)) else $error("external source counted without edge");
	ps_gate_a: assert property (@(posedge CLK) disable iff (RESET)
		!option_ff.assign_wd && !ps_out && !wr_cnt
		|=> count_ff == $past(count_ff)) else $error("count stepped without prescaler");
	wd_post_a: assert property (@(posedge CLK) disable iff (RESET)
		!option_ff.assign_wd |-> WATCHDOG_POST_TICK == WATCHDOG_TICK)
		else $error("watchdog divided while prescaler owned by timer");
	single_user_a: assert property (@(posedge CLK) disable iff (RESET)
		option_ff.assign_wd && !WATCHDOG_TICK |-> !WATCHDOG_POST_TICK)
		else $error("postscaler fed by timer source");
endmodule

// [frt_timer_tb_top.sv]
// self-checking bench for the free-running timer
`timescale 1ns/100ps
`include "frt_defs.svh"
module frt_timer_tb_top;
	import frt_pkg::*;
	// ********
	// signals
	// ********
	typedef struct {
		logic [7:0] opt;
		int         gap;
	} frt_row_t;
	logic         clk = 1'b0;
	logic         reset = 1'b1;
	logic         pin = 1'b0;
	logic         wdt = 1'b0;
	frt_axi_req_t req = '0;
	frt_axi_rsp_t rsp;
	logic         irq;
	logic         post;
	int           err_total = 0;
	int           n_tests = 0;
	int           irqs = 0;
	int           posts = 0;
	logic [31:0]  rd;
	logic [1:0]   rr;
	// gap is cycles between wraps: 256 steps times the prescale ratio, or 256 for 8'h88 where the prescaler is assigned to the watchdog
	frt_row_t     rows [8] = '{'{8'h88, 256}, '{8'h80, 512}, '{8'h81, 1024},
		'{8'h82, 2048}, '{8'h83, 4096}, '{8'h84, 8192}, '{8'h85, 16384},
		'{8'hC6, 32768}};

	frt_timer u_dut (
		.CLK                (clk),
		.RESET              (reset),
		.TIMER_INPUT_PIN    (pin),
		.WATCHDOG_TICK      (wdt),
		.AXI_REQ            (req),
		.AXI_RSP            (rsp),
		.TIMER_IRQ          (irq),
		.WATCHDOG_POST_TICK (post)
	);

	always #2 clk = ~clk;
	always @(posedge clk) if (irq === 1'b1) irqs++;
	always @(posedge clk) if (post === 1'b1) posts++;

	// ********
	// tasks
	// ********
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stuck;
		cmp(32'h0000_0000, 32'h0000_0001);
		tally_and_finish;
	endtask
	// both channels offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		int n;
		req.awaddr <= a;
		req.wdata <= {24'h00_0000, d};
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				req.bready <= 1'b0;
				rr = rsp.bresp;
				@(posedge clk);
				return;
			end
		end
		stuck();
	endtask
	task automatic rdr(input logic [3:0] a);
		int n;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				req.rready <= 1'b0;
				rd = rsp.rdata;
				rr = rsp.rresp;
				@(posedge clk);
				return;
			end
		end
		stuck();
	endtask
	task automatic chk(input logic [3:0] a, input logic [31:0] e);
		rdr(a);
		cmp(rd, e);
	endtask
	task automatic wait_irq(input int lim, output int k);
		for (k = 1; k <= lim; k++) begin
			@(posedge clk);
			if (irq === 1'b1)
				return;
		end
		stuck();
	endtask
	// slow edges so the two-flop synchroniser sees every level
	task automatic pulse_pin(input int cnt);
		repeat (cnt) begin
			pin <= 1'b1;
			repeat (4) @(posedge clk);
			pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task automatic tick(input int cnt);
		repeat (cnt) begin
			wdt <= 1'b1;
			@(posedge clk);
			wdt <= 1'b0;
			@(posedge clk);
		end
	endtask

	// ********
	// sequence
	// ********
	initial begin
		int k;
		int b;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			wr(`FRT_OFF_OPTION, rows[i].opt);
			chk(`FRT_OFF_OPTION, {24'h00_0000, rows[i].opt});
			wr(`FRT_OFF_COUNT, 8'hFE);
			wait_irq(rows[i].gap, k);
			wait_irq(rows[i].gap + 2, k);
			cmp(k, rows[i].gap);
			$display("row %0d done", i);
		end
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk(`FRT_OFF_OPTION, 32'h0000_00FF);
		chk(`FRT_OFF_COUNT, 32'h0000_0000);
		chk(`FRT_OFF_STATUS, 32'h0000_0001);
		chk(4'hC, 32'h0000_0000);
		cmp(rr, 2'b10);
		wr(4'hC, 8'h12);
		cmp(rr, 2'b10);
		$display("reset and decode done");
		wr(`FRT_OFF_OPTION, 8'h08);
		cmp(rr, 2'b00);
		b = irqs;
		repeat (600) @(posedge clk);
		cmp(irqs - b, 0);
		chk(`FRT_OFF_STATUS, 32'h0000_0001);
		cmp(rr, 2'b00);
		$display("masked rollover done");
		wr(`FRT_OFF_OPTION, 8'hA8);
		wr(`FRT_OFF_COUNT, 8'h5A);
		chk(`FRT_OFF_COUNT, 32'h0000_005A);
		pulse_pin(3);
		chk(`FRT_OFF_COUNT, 32'h0000_005D);
		wr(`FRT_OFF_OPTION, 8'hB8);
		pulse_pin(2);
		chk(`FRT_OFF_COUNT, 32'h0000_005F);
		wr(`FRT_OFF_COUNT, 8'hFF);
		b = irqs;
		pulse_pin(1);
		repeat (8) @(posedge clk);
		cmp(irqs - b, 1);
		chk(`FRT_OFF_COUNT, 32'h0000_0000);
		// prescaler phase is unknown, so only whole periods are fed
		wr(`FRT_OFF_OPTION, 8'hA0);
		wr(`FRT_OFF_COUNT, 8'h00);
		pulse_pin(4);
		chk(`FRT_OFF_COUNT, 32'h0000_0002);
		chk(`FRT_OFF_STATUS, 32'h0000_0000);
		$display("external source done");
		wr(`FRT_OFF_OPTION, 8'h89);
		b = posts;
		tick(8);
		cmp(posts - b, 2);
		// widest ratio only through the watchdog path, a timer wrap would take too long
		wr(`FRT_OFF_OPTION, 8'h8F);
		b = posts;
		tick(256);
		cmp(posts - b, 1);
		wr(`FRT_OFF_OPTION, 8'h80);
		b = posts;
		tick(3);
		cmp(posts - b, 3);
		$display("watchdog postscaler done");
		tally_and_finish();
	end
endmodule
